// ===== src/unified_map_pkg.sv
// constants, types and helpers of the unified memory map decoder
// Overview of operation
// - code space is 16 bits wide and read only; fetches decode through it
// - data space: lower half direct or indirect, upper half indirect only
// - external data access to a block behind the decoder blocks instruction prefetch while it is in progress; idata alias and unmapped accesses do not
// - sfr space uses 7-bit addresses; multiples of eight are bit addressable
// - code and external data spaces decode identically, with ram and sfr aliases
// - external data accesses work across the map but never alter flash
// - flash decodes from zero up to 0x1fff, 0x3fff or 0x7fff per variant
// - sram of 1, 2 or 4 kb decodes from 0xf000
// - 32 kb variant drops 0xfda2 to 0xfeff on entering the two deepest sleeps
// - 0xff00 to 0xffff is the same storage as the 256-byte data space
// - 0xdf00 to 0xdf3d goes to the radio register block
// - 0xdf40 to 0xdf48 goes to the serial-audio register block
// - 0xdf80 to 0xdfff reaches the sfrs except those inside the core
// - 0xde00 to 0xde3f goes to usb only on the usb variant
// - fetches aimed at sram return sram contents, so code runs from sram
// - dma reaches every memory and register block except the core-internal sfrs through the external data map
// - core-internal sfrs are reachable only through sfr space, never the map
// - sram beyond the fitted size stays unimplemented
`default_nettype none
package unified_map_pkg;

	////////////////////////////////////////////////////////////////////////////////
	localparam logic [1:0] SPACE_CODE = 2'h0;
	localparam logic [1:0] SPACE_XDATA = 2'h1;
	localparam logic [1:0] SPACE_DATA = 2'h2;
	localparam logic [1:0] SPACE_SFR = 2'h3;

	localparam int KB = 1024;
	localparam int VOLATILE_VARIANT_KB = 32;
	localparam int FLASH_PER_RAM = 8;
	localparam int IDATA_BYTES = 256;
	localparam logic [15:0] FLASH_BASE = 16'h0000;
	localparam logic [15:0] SRAM_BASE = 16'hf000;
	localparam logic [15:0] IDATA_BASE = 16'hff00;
	localparam logic [15:0] RADIO_LO = 16'hdf00;
	localparam logic [15:0] RADIO_HI = 16'hdf3d;
	localparam logic [15:0] I2S_LO = 16'hdf40;
	localparam logic [15:0] I2S_HI = 16'hdf48;
	localparam logic [15:0] SFR_LO = 16'hdf80;
	localparam logic [15:0] SFR_HI = 16'hdfff;
	localparam logic [15:0] USB_LO = 16'hde00;
	localparam logic [15:0] USB_HI = 16'hde3f;
	localparam logic [15:0] VOLATILE_LO = 16'hfda2;
	localparam logic [15:0] VOLATILE_HI = 16'hfeff;
	localparam logic [7:0] BIT_DATA_BASE = 8'h20;
	localparam logic [7:0] BYTE_MASK = 8'hff;
	localparam logic [7:0] BIT_ONE = 8'h01;
	localparam logic [7:0] READ_IDLE = 8'h00;
	// plain default: stack pointer, data pointers, psw, accumulator, b
	localparam logic [127:0] CORE_SFR_MASK_DEF = 128'h0001_0001_0001_0000_0000_0000_0004_003e;

	////////////////////////////////////////////////////////////////////////////////
	typedef enum logic [8:0] {
		TGT_NONE = 9'h001,
		TGT_FLASH = 9'h002,
		TGT_SRAM = 9'h004,
		TGT_IDATA = 9'h008,
		TGT_RADIO = 9'h010,
		TGT_I2S = 9'h020,
		TGT_SFR = 9'h040,
		TGT_USB = 9'h080,
		TGT_CORE = 9'h100
	} target_type;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_LOCAL = 3'h2,
		ST_EXT = 3'h4
	} state_type;

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
		input logic [15:0] hi);
		return (a >= lo) && (a <= hi);
	endfunction

	function automatic logic [15:0] flash_end(input int flash_kb);
		return 16'(flash_kb * KB - 1);
	endfunction

	// the top 256 bytes of the ram are the data space itself
	function automatic logic [15:0] sram_end(input int flash_kb);
		return 16'(int'(SRAM_BASE) + (flash_kb / FLASH_PER_RAM) * KB - IDATA_BYTES - 1);
	endfunction

endpackage
`default_nettype wire

// ===== src/unified_map_classify.sv
// address classifier of the unified code / external data map
`timescale 1ns/1ps
`default_nettype none
module unified_map_classify #(
	parameter int FLASH_KB = 32,
	parameter bit USB_PRESENT = 1'b1,
	parameter logic [127:0] CORE_SFR_MASK = unified_map_pkg::CORE_SFR_MASK_DEF
) (
	input wire logic [15:0] addr_i,
	output unified_map_pkg::target_type target_o,
	output logic [15:0] offset_o
);

	localparam logic [15:0] FLASH_END = unified_map_pkg::flash_end(FLASH_KB);
	localparam logic [15:0] SRAM_END = unified_map_pkg::sram_end(FLASH_KB);

	always_comb begin
		target_o = unified_map_pkg::TGT_NONE;
		offset_o = '0;
		if (addr_i <= FLASH_END) begin
			target_o = unified_map_pkg::TGT_FLASH;
			offset_o = addr_i - unified_map_pkg::FLASH_BASE;
		end else if (unified_map_pkg::in_range(addr_i, unified_map_pkg::SRAM_BASE, SRAM_END)) begin
			// holes above the fitted ram fall through to no target
			target_o = unified_map_pkg::TGT_SRAM;
			offset_o = addr_i - unified_map_pkg::SRAM_BASE;
		end else if (addr_i >= unified_map_pkg::IDATA_BASE) begin
			target_o = unified_map_pkg::TGT_IDATA;
			offset_o = {8'h00, addr_i[7:0]};
		end else if (unified_map_pkg::in_range(addr_i, unified_map_pkg::RADIO_LO,
			unified_map_pkg::RADIO_HI)) begin
			target_o = unified_map_pkg::TGT_RADIO;
			offset_o = addr_i - unified_map_pkg::RADIO_LO;
		end else if (unified_map_pkg::in_range(addr_i, unified_map_pkg::I2S_LO,
			unified_map_pkg::I2S_HI)) begin
			target_o = unified_map_pkg::TGT_I2S;
			offset_o = addr_i - unified_map_pkg::I2S_LO;
		end else if (unified_map_pkg::in_range(addr_i, unified_map_pkg::SFR_LO,
			unified_map_pkg::SFR_HI)) begin
			// core-internal registers have no alias here
			if (!CORE_SFR_MASK[addr_i[6:0]]) begin
				target_o = unified_map_pkg::TGT_SFR;
				offset_o = {9'h000, addr_i[6:0]};
			end
		end else if (USB_PRESENT && unified_map_pkg::in_range(addr_i, unified_map_pkg::USB_LO,
			unified_map_pkg::USB_HI)) begin
			target_o = unified_map_pkg::TGT_USB;
			offset_o = addr_i - unified_map_pkg::USB_LO;
		end
	end

endmodule
`default_nettype wire

// ===== src/unified_memory_map_decoder.sv
// unified memory map decoder with the internal data ram
`timescale 1ns/1ps
`default_nettype none
module unified_memory_map_decoder #(
	parameter int FLASH_KB = 32,
	parameter bit USB_PRESENT = 1'b1,
	parameter logic [127:0] CORE_SFR_MASK = unified_map_pkg::CORE_SFR_MASK_DEF
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic req_valid_i,
	input wire logic [1:0] req_space_i,
	input wire logic [15:0] req_addr_i,
	input wire logic req_write_i,
	input wire logic req_direct_i,
	input wire logic req_bit_i,
	input wire logic [7:0] req_wdata_i,
	output logic req_ready_o,
	output logic rsp_valid_o,
	output logic [7:0] rsp_rdata_o,
	output logic rsp_err_o,
	output logic fetch_stall_o,
	output logic sel_flash_o,
	output logic sel_sram_o,
	output logic sel_radio_o,
	output logic sel_i2s_o,
	output logic sel_sfr_o,
	output logic sel_usb_o,
	output logic sel_core_o,
	output logic [15:0] tgt_offset_o,
	output logic tgt_write_o,
	output logic [7:0] tgt_wdata_o,
	output logic [7:0] tgt_mask_o,
	input wire logic tgt_ack_i,
	input wire logic [7:0] tgt_rdata_i,
	input wire logic sleep_mode_second_deepest_i,
	input wire logic sleep_mode_deepest_i,
	output logic sram_power_down_o
);

	localparam logic [15:0] FLASH_END = unified_map_pkg::flash_end(FLASH_KB);
	localparam logic [15:0] SRAM_END = unified_map_pkg::sram_end(FLASH_KB);
	localparam bit HAS_VOLATILE = (FLASH_KB == unified_map_pkg::VOLATILE_VARIANT_KB);

	////////////////////////////////////////////////////////////////////////////////
	function automatic unified_map_pkg::target_type sfr_target(input logic [6:0] a);
		return CORE_SFR_MASK[a] ? unified_map_pkg::TGT_CORE : unified_map_pkg::TGT_SFR;
	endfunction

	function automatic logic is_external(input unified_map_pkg::target_type t);
		return (t != unified_map_pkg::TGT_NONE) && (t != unified_map_pkg::TGT_IDATA);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	unified_map_pkg::target_type map_target;
	unified_map_pkg::target_type next_target;
	unified_map_pkg::target_type cur_target;
	unified_map_pkg::state_type state;
	logic [15:0] map_offset;
	logic [15:0] next_offset;
	logic [7:0] next_mask;
	logic [7:0] idata_mem [unified_map_pkg::IDATA_BYTES];
	logic [7:0] idata_rd;
	logic take;

	assign take = req_valid_i && req_ready_o;

	unified_map_classify #(
		.FLASH_KB(FLASH_KB),
		.USB_PRESENT(USB_PRESENT),
		.CORE_SFR_MASK(CORE_SFR_MASK)
	) u_classify (
		.addr_i(req_addr_i),
		.target_o(map_target),
		.offset_o(map_offset)
	);

	////////////////////////////////////////////////////////////////////////////////
	// per-space decode; one target code, so never two selects
	always_comb begin
		next_target = unified_map_pkg::TGT_NONE;
		next_offset = '0;
		next_mask = unified_map_pkg::BYTE_MASK;
		unique case (req_space_i)
			unified_map_pkg::SPACE_CODE: begin
				// shares the external data decode, so sram fetches work
				if (!req_write_i) begin
					next_target = map_target;
					next_offset = map_offset;
				end
			end
			unified_map_pkg::SPACE_XDATA: begin
				// the whole map, which is how dma reaches every block but the core-internal sfrs
				next_target = map_target;
				next_offset = map_offset;
				if (req_write_i && map_target == unified_map_pkg::TGT_FLASH) begin
					next_target = unified_map_pkg::TGT_NONE;
				end
			end
			unified_map_pkg::SPACE_DATA: begin
				if (req_direct_i && req_addr_i[7]) begin
					// direct upper half lands in sfr space
					next_target = sfr_target(req_addr_i[6:0]);
					next_offset = {9'h000, req_addr_i[6:0]};
				end else begin
					next_target = unified_map_pkg::TGT_IDATA;
					next_offset = {8'h00, req_addr_i[7:0]};
				end
			end
			unified_map_pkg::SPACE_SFR: begin
				if (req_bit_i) begin
					next_mask = unified_map_pkg::BIT_ONE << req_addr_i[2:0];
					if (req_addr_i[7]) begin
						next_target = sfr_target({req_addr_i[6:3], 3'b000});
						next_offset = {9'h000, req_addr_i[6:3], 3'b000};
					end else begin
						next_target = unified_map_pkg::TGT_IDATA;
						next_offset = {8'h00, unified_map_pkg::BIT_DATA_BASE + {4'h0, req_addr_i[6:3]}};
					end
				end else begin
					next_target = sfr_target(req_addr_i[6:0]);
					next_offset = {9'h000, req_addr_i[6:0]};
				end
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// sequencing: one access outstanding at a time
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			state <= unified_map_pkg::ST_IDLE;
		end else begin
			unique case (state)
				unified_map_pkg::ST_IDLE: begin
					if (take) begin
						state <= is_external(next_target) ? unified_map_pkg::ST_EXT
							: unified_map_pkg::ST_LOCAL;
					end
				end
				unified_map_pkg::ST_LOCAL: begin
					state <= unified_map_pkg::ST_IDLE;
				end
				unified_map_pkg::ST_EXT: begin
					if (tgt_ack_i) begin
						state <= unified_map_pkg::ST_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			req_ready_o <= 1'b1;
		end else if (take) begin
			req_ready_o <= 1'b0;
		end else if (state == unified_map_pkg::ST_LOCAL ||
			(state == unified_map_pkg::ST_EXT && tgt_ack_i)) begin
			req_ready_o <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// target strobes, one cycle wide
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			sel_flash_o <= 1'b0;
			sel_sram_o <= 1'b0;
			sel_radio_o <= 1'b0;
			sel_i2s_o <= 1'b0;
			sel_sfr_o <= 1'b0;
			sel_usb_o <= 1'b0;
			sel_core_o <= 1'b0;
			tgt_write_o <= 1'b0;
		end else begin
			sel_flash_o <= take && next_target == unified_map_pkg::TGT_FLASH;
			sel_sram_o <= take && next_target == unified_map_pkg::TGT_SRAM;
			sel_radio_o <= take && next_target == unified_map_pkg::TGT_RADIO;
			sel_i2s_o <= take && next_target == unified_map_pkg::TGT_I2S;
			sel_sfr_o <= take && next_target == unified_map_pkg::TGT_SFR;
			sel_usb_o <= take && next_target == unified_map_pkg::TGT_USB;
			sel_core_o <= take && next_target == unified_map_pkg::TGT_CORE;
			tgt_write_o <= take && req_write_i && is_external(next_target);
		end
	end

	// held until the next accepted request
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			cur_target <= unified_map_pkg::TGT_NONE;
			tgt_offset_o <= '0;
			tgt_wdata_o <= '0;
			tgt_mask_o <= unified_map_pkg::BYTE_MASK;
		end else if (take) begin
			cur_target <= next_target;
			tgt_offset_o <= next_offset;
			tgt_wdata_o <= req_wdata_i;
			tgt_mask_o <= next_mask;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// one array serves both the data space and its alias at the top of the map
	always_ff @(posedge core_clk_i) begin
		if (take && next_target == unified_map_pkg::TGT_IDATA) begin
			if (req_write_i) begin
				idata_mem[next_offset[7:0]] <= (idata_mem[next_offset[7:0]] & ~next_mask) |
					(req_wdata_i & next_mask);
			end
			idata_rd <= idata_mem[next_offset[7:0]];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// unmapped reads answer zero with an error; content is not to be relied on
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			rsp_valid_o <= 1'b0;
			rsp_rdata_o <= unified_map_pkg::READ_IDLE;
			rsp_err_o <= 1'b0;
		end else begin
			rsp_valid_o <= (state == unified_map_pkg::ST_LOCAL) ||
				(state == unified_map_pkg::ST_EXT && tgt_ack_i);
			rsp_err_o <= (state == unified_map_pkg::ST_LOCAL) &&
				(cur_target == unified_map_pkg::TGT_NONE);
			if (state == unified_map_pkg::ST_LOCAL) begin
				rsp_rdata_o <= (cur_target == unified_map_pkg::TGT_IDATA) ? idata_rd
					: unified_map_pkg::READ_IDLE;
			end else if (state == unified_map_pkg::ST_EXT && tgt_ack_i) begin
				rsp_rdata_o <= tgt_rdata_i;
			end
		end
	end

	// shared fetch bus is busy for the whole external data access to a block behind the decoder
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			fetch_stall_o <= 1'b0;
		end else if (take && req_space_i == unified_map_pkg::SPACE_XDATA &&
			is_external(next_target)) begin
			fetch_stall_o <= 1'b1;
		end else if (state == unified_map_pkg::ST_EXT && tgt_ack_i) begin
			fetch_stall_o <= 1'b0;
		end
	end

	// ram macro drops the volatile window when a deep sleep is entered
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			sram_power_down_o <= 1'b0;
		end else begin
			sram_power_down_o <= HAS_VOLATILE &&
				(sleep_mode_second_deepest_i || sleep_mode_deepest_i);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	property p_one_select;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		$onehot0({sel_flash_o, sel_sram_o, sel_radio_o, sel_i2s_o, sel_sfr_o, sel_usb_o,
			sel_core_o});
	endproperty
	a_one_select: assert property (p_one_select) else $error("two targets selected");

	property p_code_write_refused;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		take && req_space_i == unified_map_pkg::SPACE_CODE && req_write_i
			|=> !tgt_write_o ##1 rsp_valid_o && rsp_err_o;
	endproperty
	a_code_write_refused: assert property (p_code_write_refused) else $error("code write taken");

	property p_flash_not_written;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		sel_flash_o |-> !tgt_write_o && tgt_offset_o <= FLASH_END;
	endproperty
	a_flash_not_written: assert property (p_flash_not_written) else $error("flash write");

	property p_sram_window;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		take && req_space_i != unified_map_pkg::SPACE_DATA && req_space_i !=
			unified_map_pkg::SPACE_SFR && !req_write_i &&
			unified_map_pkg::in_range(req_addr_i, unified_map_pkg::SRAM_BASE, SRAM_END)
			|=> sel_sram_o && tgt_offset_o == $past(req_addr_i) - unified_map_pkg::SRAM_BASE;
	endproperty
	a_sram_window: assert property (p_sram_window) else $error("sram not selected");

	property p_sram_hole;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		take && req_space_i == unified_map_pkg::SPACE_XDATA && req_addr_i > SRAM_END &&
			req_addr_i < unified_map_pkg::IDATA_BASE
			|=> !sel_sram_o ##1 rsp_valid_o && rsp_err_o;
	endproperty
	a_sram_hole: assert property (p_sram_hole) else $error("hole decoded");

	property p_idata_alias;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		take && req_space_i == unified_map_pkg::SPACE_XDATA &&
			req_addr_i >= unified_map_pkg::IDATA_BASE
			|=> tgt_offset_o == {8'h00, $past(req_addr_i[7:0])} ##1 rsp_valid_o && !rsp_err_o;
	endproperty
	a_idata_alias: assert property (p_idata_alias) else $error("alias missed");

	property p_radio;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		take && req_space_i == unified_map_pkg::SPACE_XDATA &&
			unified_map_pkg::in_range(req_addr_i, unified_map_pkg::RADIO_LO, unified_map_pkg::RADIO_HI)
			|=> sel_radio_o;
	endproperty
	a_radio: assert property (p_radio) else $error("radio not selected");

	property p_i2s;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		take && req_space_i == unified_map_pkg::SPACE_XDATA &&
			unified_map_pkg::in_range(req_addr_i, unified_map_pkg::I2S_LO, unified_map_pkg::I2S_HI)
			|=> sel_i2s_o;
	endproperty
	a_i2s: assert property (p_i2s) else $error("audio block not selected");

	property p_usb;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		take && req_space_i == unified_map_pkg::SPACE_XDATA &&
			unified_map_pkg::in_range(req_addr_i, unified_map_pkg::USB_LO, unified_map_pkg::USB_HI)
			|=> sel_usb_o == USB_PRESENT;
	endproperty
	a_usb: assert property (p_usb) else $error("usb decode wrong");

	property p_core_hidden;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		take && req_space_i == unified_map_pkg::SPACE_XDATA && req_addr_i >= unified_map_pkg::SFR_LO
			&& req_addr_i < unified_map_pkg::SRAM_BASE && CORE_SFR_MASK[req_addr_i[6:0]]
			|=> !sel_sfr_o && !sel_core_o ##1 rsp_err_o;
	endproperty
	a_core_hidden: assert property (p_core_hidden) else $error("core sfr aliased");

	property p_direct_upper;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		take && req_space_i == unified_map_pkg::SPACE_DATA && req_direct_i && req_addr_i[7]
			|=> sel_sfr_o || sel_core_o;
	endproperty
	a_direct_upper: assert property (p_direct_upper) else $error("direct upper hit ram");

	property p_bit_mask;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		take && req_space_i == unified_map_pkg::SPACE_SFR && req_bit_i
			|=> tgt_mask_o == (unified_map_pkg::BIT_ONE << $past(req_addr_i[2:0])) &&
			tgt_offset_o[2:0] == ($past(req_addr_i[7]) ? 3'b000 : $past(req_addr_i[5:3]));
	endproperty
	a_bit_mask: assert property (p_bit_mask) else $error("bad bit mask");

	property p_stall;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		fetch_stall_o && !tgt_ack_i |=> fetch_stall_o && !req_ready_o;
	endproperty
	a_stall: assert property (p_stall) else $error("stall dropped early");

	property p_sleep_drop;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(sleep_mode_second_deepest_i || sleep_mode_deepest_i) |=> sram_power_down_o == HAS_VOLATILE;
	endproperty
	a_sleep_drop: assert property (p_sleep_drop) else $error("volatile window kept");

endmodule
`default_nettype wire

// ===== tb/target_model.sv
// responder model for the register and memory blocks behind the decoder
`timescale 1ns/1ps
`default_nettype none
module target_model (
	input wire logic clk_i,
	input wire logic [6:0] sel_i,
	input wire logic [15:0] offset_i,
	input wire logic write_i,
	input wire logic [7:0] wdata_i,
	input wire logic [7:0] mask_i,
	input wire logic [3:0] lat_i,
	output logic ack_o,
	output logic [7:0] rdata_o
);
	logic [7:0] mem [0:2047];
	logic [10:0] idx;
	logic pend;
	logic wr;
	logic [3:0] cnt;
	initial begin
		ack_o = 1'b0;
		rdata_o = 8'h00;
		pend = 1'b0;
	end
	always @(posedge clk_i) begin
		#1;
		ack_o = 1'b0;
		// released data lines keep toggling so a stale value never passes
		rdata_o = ~rdata_o;
		if (|sel_i) begin
			pend = 1'b1;
			cnt = lat_i;
			wr = write_i;
			for (int i = 0; i < 7; i++) begin
				if (sel_i[i]) begin
					idx = {i[2:0], offset_i[7:0]};
				end
			end
		end
		if (pend && cnt == 4'h0) begin
			pend = 1'b0;
			ack_o = 1'b1;
			// masked merge keeps bit writes from disturbing neighbours
			if (wr) begin
				mem[idx] = (mem[idx] & ~mask_i) | (wdata_i & mask_i);
			end
			rdata_o = mem[idx];
		end else if (pend) begin
			cnt = cnt - 4'h1;
		end
	end
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// self-checking bench of the unified memory map decoder
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic core_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic req_valid_i = 1'b0;
	logic [1:0] req_space_i = 2'h0;
	logic [15:0] req_addr_i = 16'h0000;
	logic req_write_i = 1'b0;
	logic req_direct_i = 1'b0;
	logic req_bit_i = 1'b0;
	logic [7:0] req_wdata_i = 8'h00;
	logic slp2 = 1'b0;
	logic slp3 = 1'b0;
	logic [3:0] lat = 4'h0;
	logic req_ready_o, rsp_valid_o, rsp_err_o, fetch_stall_o, tgt_write_o, sram_power_down_o;
	logic sel_flash_o, sel_sram_o, sel_radio_o, sel_i2s_o, sel_sfr_o, sel_usb_o, sel_core_o;
	logic [7:0] rsp_rdata_o, tgt_wdata_o, tgt_mask_o, tgt_rdata_i;
	logic [15:0] tgt_offset_o;
	logic tgt_ack_i;
	logic [6:0] sv;
	logic [6:0] sv_seen;
	logic s_valid, s_err;
	logic [15:0] off;
	logic [7:0] rd, msk;
	logic er, wrp, stl;
	int k;
	int bad_count = 0;
	int tests_run = 0;
	logic [23:0] map_tab [17] = '{24'h0000_01, 24'h7fff_01, 24'h8000_00, 24'hf000_02,
		24'hfeff_02, 24'hdf00_04, 24'hdf3d_04, 24'hdf3e_00, 24'hdf40_08, 24'hdf48_08,
		24'hdf49_00, 24'hdf80_10, 24'hdf81_00, 24'hdfff_10, 24'hde00_20, 24'hde3f_20,
		24'hde40_00};
	assign sv = {sel_core_o, sel_usb_o, sel_sfr_o, sel_i2s_o, sel_radio_o, sel_sram_o, sel_flash_o};
	always #5 core_clk_i = ~core_clk_i;
	unified_memory_map_decoder i_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
		.req_valid_i(req_valid_i), .req_space_i(req_space_i), .req_addr_i(req_addr_i),
		.req_write_i(req_write_i), .req_direct_i(req_direct_i), .req_bit_i(req_bit_i),
		.req_wdata_i(req_wdata_i), .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o),
		.rsp_rdata_o(rsp_rdata_o), .rsp_err_o(rsp_err_o), .fetch_stall_o(fetch_stall_o),
		.sel_flash_o(sel_flash_o), .sel_sram_o(sel_sram_o), .sel_radio_o(sel_radio_o),
		.sel_i2s_o(sel_i2s_o), .sel_sfr_o(sel_sfr_o), .sel_usb_o(sel_usb_o),
		.sel_core_o(sel_core_o), .tgt_offset_o(tgt_offset_o), .tgt_write_o(tgt_write_o),
		.tgt_wdata_o(tgt_wdata_o), .tgt_mask_o(tgt_mask_o), .tgt_ack_i(tgt_ack_i),
		.tgt_rdata_i(tgt_rdata_i), .sleep_mode_second_deepest_i(slp2),
		.sleep_mode_deepest_i(slp3), .sram_power_down_o(sram_power_down_o));
	// smallest variant without usb, shares the request bus and the responder's ack;
	// its targets are a subset of the large one's, so both answer on the same edge when lat is zero or both select a block
	unified_memory_map_decoder #(.FLASH_KB(8), .USB_PRESENT(1'b0)) i_dut_small (
		.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid_i),
		.req_space_i(req_space_i), .req_addr_i(req_addr_i), .req_write_i(req_write_i),
		.req_direct_i(req_direct_i), .req_bit_i(req_bit_i), .req_wdata_i(req_wdata_i),
		.req_ready_o(), .rsp_valid_o(s_valid), .rsp_rdata_o(), .rsp_err_o(s_err),
		.fetch_stall_o(), .sel_flash_o(), .sel_sram_o(), .sel_radio_o(), .sel_i2s_o(),
		.sel_sfr_o(), .sel_usb_o(), .sel_core_o(), .tgt_offset_o(), .tgt_write_o(),
		.tgt_wdata_o(), .tgt_mask_o(), .tgt_ack_i(tgt_ack_i), .tgt_rdata_i(tgt_rdata_i),
		.sleep_mode_second_deepest_i(slp2), .sleep_mode_deepest_i(slp3),
		.sram_power_down_o());
	target_model i_tgt (.clk_i(core_clk_i), .sel_i(sv), .offset_i(tgt_offset_o),
		.write_i(tgt_write_o), .wdata_i(tgt_wdata_o), .mask_i(tgt_mask_o), .lat_i(lat),
		.ack_o(tgt_ack_i), .rdata_o(tgt_rdata_i));
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
		tests_run++;
		if (s !== e) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// entered just after an edge; the request is taken at the next edge
	task automatic acc(input logic [1:0] sp, input logic [15:0] a, input logic w,
		input logic dir, input logic bt, input logic [7:0] wd);
		{req_valid_i, req_space_i, req_addr_i, req_write_i} = {1'b1, sp, a, w};
		{req_direct_i, req_bit_i, req_wdata_i} = {dir, bt, wd};
		@(posedge core_clk_i);
		#1 req_valid_i = 1'b0;
		{sv_seen, stl, wrp, k} = '0;
		k = 1;
		while (rsp_valid_o !== 1'b1 && k < 30) begin
			if ($countones(sv) > 1) chk("one_hot", 16'(sv), 16'h0000);
			if (|sv) {off, msk, wrp} = {tgt_offset_o, tgt_mask_o, tgt_write_o};
			sv_seen |= sv;
			stl |= fetch_stall_o;
			@(posedge core_clk_i);
			#1 k++;
		end
		if (k >= 30) begin
			bad_count++;
			summarize;
		end
		{rd, er} = {rsp_rdata_o, rsp_err_o};
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_map;
		logic [15:0] b;
		for (int s = 0; s < 2; s++) begin
			foreach (map_tab[i]) begin
				acc(2'(s), map_tab[i][23:8], 1'b0, 1'b0, 1'b0, 8'h00);
				chk("sel", 16'(sv_seen), 16'(map_tab[i][6:0]));
				chk("err", 16'(er), 16'(map_tab[i][6:0] == 7'h00));
				chk("latency", 16'(k), 16'h0002);
				b = map_tab[i][1] ? 16'hf000 : map_tab[i][2] ? 16'hdf00 : 16'h0000;
				b = map_tab[i][3] ? 16'hdf40 : map_tab[i][5] ? 16'hde00 : b;
				if (map_tab[i][6:0] inside {7'h01, 7'h02, 7'h04, 7'h08, 7'h20})
					chk("offset", off, map_tab[i][23:8] - b);
			end
		end
	endtask
	task automatic t_refuse;
		acc(2'h1, 16'h0010, 1'b1, 1'b0, 1'b0, 8'h5a);
		chk("flash_wr", {7'h00, sv_seen, 1'b0, er}, 16'h0001);
		acc(2'h0, 16'hf000, 1'b1, 1'b0, 1'b0, 8'h5a);
		chk("code_wr", {7'h00, sv_seen, 1'b0, er}, 16'h0001);
		acc(2'h1, 16'h8000, 1'b1, 1'b0, 1'b0, 8'h5a);
		chk("gap_wr", {7'h00, sv_seen, 1'b0, er}, 16'h0001);
	endtask
	task automatic t_sram;
		lat = 4'h3;
		acc(2'h1, 16'hf010, 1'b1, 1'b0, 1'b0, 8'hc3);
		chk("slow_wr", {sv_seen, wrp, stl, er, 6'(k)}, {7'h02, 3'b110, 6'h05});
		lat = 4'h0;
		acc(2'h0, 16'hf010, 1'b0, 1'b0, 1'b0, 8'h00);
		chk("fetch", {stl, er, 6'h00, rd}, 16'h00c3);
	endtask
	task automatic t_idata;
		acc(2'h1, 16'hff05, 1'b1, 1'b0, 1'b0, 8'ha5);
		acc(2'h2, 16'h0005, 1'b0, 1'b1, 1'b0, 8'h00);
		chk("alias_rd", {er, 7'h00, rd}, 16'h00a5);
		acc(2'h2, 16'h0090, 1'b1, 1'b0, 1'b0, 8'h3c);
		acc(2'h1, 16'hff90, 1'b0, 1'b0, 1'b0, 8'h00);
		chk("upper_rd", {sv_seen, 1'b0, rd}, 16'h003c);
		acc(2'h2, 16'h0090, 1'b0, 1'b1, 1'b0, 8'h00);
		chk("direct_hi", 16'(sv_seen), 16'h0010);
	endtask
	task automatic t_sfr;
		acc(2'h3, 16'h0081, 1'b0, 1'b0, 1'b0, 8'h00);
		chk("core_sfr", 16'(sv_seen), 16'h0040);
		acc(2'h3, 16'h0083, 1'b1, 1'b0, 1'b1, 8'h08);
		chk("bit_hi", {sv_seen, 1'b0, msk}, 16'h2008);
		acc(2'h2, 16'h0021, 1'b1, 1'b1, 1'b0, 8'hff);
		acc(2'h3, 16'h000b, 1'b1, 1'b0, 1'b1, 8'h00);
		acc(2'h2, 16'h0021, 1'b0, 1'b1, 1'b0, 8'h00);
		chk("bit_lo", 16'(rd), 16'h00f7);
	endtask
	// unmapped answers are only checked for the error flag, never for their data
	task automatic t_small;
		acc(2'h1, 16'hf300, 1'b0, 1'b0, 1'b0, 8'h00);
		chk("hole", {sv_seen, s_valid, s_err, 7'h00}, {7'h02, 2'b11, 7'h00});
		acc(2'h1, 16'hf2ff, 1'b0, 1'b0, 1'b0, 8'h00);
		chk("ram_top", {14'h0000, s_valid, s_err}, 16'h0002);
		acc(2'h0, 16'h2000, 1'b0, 1'b0, 1'b0, 8'h00);
		chk("flash_end", {sv_seen, 7'h00, s_valid, s_err}, {7'h01, 7'h00, 2'b11});
		acc(2'h1, 16'hde00, 1'b0, 1'b0, 1'b0, 8'h00);
		chk("no_usb", {sv_seen, 7'h00, s_valid, s_err}, {7'h20, 7'h00, 2'b11});
	endtask
	task automatic t_sleep;
		for (int i = 0; i < 2; i++) begin
			{slp3, slp2} = 2'(1 << i);
			@(posedge core_clk_i);
			#1 {slp3, slp2} = 2'b00;
			chk("pd_on", 16'(sram_power_down_o), 16'h0001);
			@(posedge core_clk_i);
			#1 chk("pd_off", 16'(sram_power_down_o), 16'h0000);
		end
	endtask
	initial begin
		repeat (2) @(posedge core_clk_i);
		#1 rst_n_i = 1'b1;
		chk("reset", {req_ready_o, rsp_valid_o, fetch_stall_o, sv, tgt_mask_o[5:0]}, 16'h803f);
		t_map;
		t_refuse;
		t_sram;
		t_idata;
		t_sfr;
		t_small;
		t_sleep;
		summarize;
	end
endmodule
`default_nettype wire
